// >>> timer_counter.sv
// sixteen-bit prescaled event counter with byte registers behind an apb slave
`timescale 1ns/1ps

// How it works
// - sync disable set with clock source set: prescaled external clock increments counter, no synchronizing stage
// - asynchronous counter mode keeps counting in sleep; overflow may wake processor
// - asynchronous counter mode count is not a valid capture/compare time base
// - count byte reads during asynchronous counting always return a clean byte
// - crystal enable bit runs the built-in oscillator between its two pins
// - compare unit special event trigger resets the counter
// - trigger-driven reset never sets the overflow flag
// - trigger reset works only in timer or synchronized counter mode
// - count write in the same cycle as a trigger wins over it
// - with trigger reset the compare pair acts as the counting period
// - no device reset clears the count bytes
// - power-on and brown-out clear control to zero; other resets keep it
// - any write to a count byte clears the prescaler
// - count is two byte registers, low byte then high byte
// - unimplemented bits of associated registers read as zero
// - clock source clear: count instruction clock, one quarter oscillator rate
// - clock source set: count rising edges of crystal pin or external pin
// - synchronized counter mode does not count in sleep; prescaler keeps running
// - synchronized counter mode synchronizes after the prescaler
module timer_counter (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic device_reset_i,
    input wire logic sleep_i,
    input wire timer_counter_pkg::apb_req_t apb_req_i,
    output timer_counter_pkg::apb_rsp_t apb_rsp_o,
    input wire logic external_count_pin_i,
    input wire logic crystal_input_pin_i,
    output logic crystal_output_pin_o,
    input wire logic [3:0] compare_unit_mode_field_i,
    input wire logic [7:0] compare_value_high_i,
    input wire logic [7:0] compare_value_low_i,
    output logic [15:0] time_base_o,
    output logic time_base_valid_o,
    output logic overflow_irq_o,
    output logic wake_o
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    timer_counter_pkg::state_t state_q;
    timer_counter_pkg::state_t state_d;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic instr_tick;
        logic source_level;
        logic source_edge;
        logic source_event;
        logic [2:0] prescale_mask;
        logic prescale_tick;
        logic async_mode;
        logic count_tick;
        logic trigger;
        logic overflow;
        logic setup;
        logic complete;
        logic write_done;
        logic [timer_counter_pkg::IDX_W-1:0] idx;
        logic idx_hit;
        logic [7:0] read_byte;
        logic [7:0] wbyte;

        state_d = state_q;
        instr_tick = 1'b0;
        source_level = 1'b0;
        source_edge = 1'b0;
        source_event = 1'b0;
        prescale_mask = 3'h0;
        prescale_tick = 1'b0;
        async_mode = 1'b0;
        count_tick = 1'b0;
        trigger = 1'b0;
        overflow = 1'b0;
        setup = 1'b0;
        complete = 1'b0;
        write_done = 1'b0;
        idx = apb_req_i.paddr[timer_counter_pkg::ADDR_W-1:2];
        idx_hit = 1'b0;
        read_byte = 8'h00;
        wbyte = apb_req_i.pwdata[7:0];

        // ------------------------------------------------------------
        // instruction clock, a quarter of the oscillator rate
        // ------------------------------------------------------------
        // the instruction clock halts in sleep, so timer mode halts too
        if (!sleep_i) begin
            instr_tick = (state_q.instr_div == timer_counter_pkg::INSTR_DIV_LAST);
            state_d.instr_div = 2'(state_q.instr_div + 2'h1);
        end

        // ------------------------------------------------------------
        // clock source and crystal amplifier
        // ------------------------------------------------------------
        // inverting amplifier, off when disabled to save drive current
        state_d.osc_drive = state_q.ctrl.crystal_osc_enable_bit & ~crystal_input_pin_i;
        source_level = state_q.ctrl.crystal_osc_enable_bit ? crystal_input_pin_i
                                                          : external_count_pin_i;
        state_d.source_prev = source_level;
        source_edge = source_level & ~state_q.source_prev;
        source_event = state_q.ctrl.clock_source_select_bit ? source_edge : instr_tick;

        // ------------------------------------------------------------
        // prescaler, 1:1 1:2 1:4 1:8
        // ------------------------------------------------------------
        unique case (state_q.ctrl.prescale_select_field)
            2'h0: prescale_mask = 3'h0;
            2'h1: prescale_mask = 3'h1;
            2'h2: prescale_mask = 3'h3;
            2'h3: prescale_mask = 3'h7;
        endcase
        if (state_q.ctrl.counter_on_bit && source_event) begin
            // in synchronized counter mode keeps counting in sleep, only the stage after it stops
            state_d.prescale_count = 3'(state_q.prescale_count + 3'h1);
            prescale_tick = ((state_q.prescale_count & prescale_mask) == prescale_mask);
        end

        // ------------------------------------------------------------
        // counting modes
        // ------------------------------------------------------------
        async_mode = state_q.ctrl.clock_source_select_bit & state_q.ctrl.sync_disable_bit;
        // one sampling stage behind the prescaler; dead while asleep
        state_d.sync_tick = prescale_tick & ~sleep_i;
        if (!state_q.ctrl.clock_source_select_bit) begin
            count_tick = prescale_tick;
        end else if (async_mode) begin
            // no sampling stage, so it also counts through sleep
            count_tick = prescale_tick;
        end else begin
            count_tick = state_q.sync_tick & state_q.ctrl.counter_on_bit & ~sleep_i;
        end
        state_d.time_base_valid = ~async_mode;

        // ------------------------------------------------------------
        // special event trigger and counting
        // ------------------------------------------------------------
        // an unsynchronized count cannot be compared reliably, so ignore it
        trigger = (compare_unit_mode_field_i == timer_counter_pkg::COMPARE_MODE_TRIGGER) &&
                  (state_q.count == {compare_value_high_i, compare_value_low_i}) &&
                  !async_mode;
        if (count_tick) begin
            if (trigger) begin
                // restart from zero, flag untouched
                state_d.count = 16'h0000;
            end else begin
                overflow = (state_q.count == timer_counter_pkg::COUNT_MAX);
                state_d.count = 16'(state_q.count + 16'h0001);
            end
        end

        // ------------------------------------------------------------
        // apb slave, answers in the first access cycle
        // ------------------------------------------------------------
        setup = apb_req_i.psel & ~apb_req_i.penable;
        complete = apb_req_i.psel & apb_req_i.penable & state_q.rsp.pready;
        write_done = complete & apb_req_i.pwrite & ~state_q.rsp.pslverr;
        unique case (idx)
            timer_counter_pkg::IDX_INTERRUPT_CONTROL: begin
                idx_hit = 1'b1;
                read_byte[timer_counter_pkg::GLOBAL_IRQ_ENABLE_POS] = state_q.global_irq_enable;
                read_byte[timer_counter_pkg::PERIPHERAL_IRQ_ENABLE_POS] =
                    state_q.peripheral_irq_enable;
            end
            timer_counter_pkg::IDX_IRQ_FLAGS_ONE: begin
                idx_hit = 1'b1;
                read_byte[timer_counter_pkg::OVERFLOW_IRQ_POS] = state_q.overflow_irq_flag;
            end
            timer_counter_pkg::IDX_COUNT_LOW_BYTE: begin
                idx_hit = 1'b1;
                // the count lives in flops of this clock, so a byte is never torn
                read_byte = state_q.count[7:0];
            end
            timer_counter_pkg::IDX_COUNT_HIGH_BYTE: begin
                idx_hit = 1'b1;
                read_byte = state_q.count[15:8];
            end
            timer_counter_pkg::IDX_COUNTER_CONTROL: begin
                idx_hit = 1'b1;
                read_byte = {2'h0, state_q.ctrl};
            end
            timer_counter_pkg::IDX_IRQ_ENABLES_ONE: begin
                idx_hit = 1'b1;
                read_byte[timer_counter_pkg::OVERFLOW_IRQ_POS] = state_q.overflow_irq_enable;
            end
            default: begin
                idx_hit = 1'b0;
            end
        endcase
        idx_hit = idx_hit & (apb_req_i.paddr[1:0] == 2'h0);
        state_d.rsp.pready = setup;
        state_d.rsp.pslverr = setup & ~idx_hit;
        if (setup) begin
            state_d.rsp.prdata = {24'h000000, read_byte};
        end else if (complete) begin
            state_d.rsp.prdata = 32'h00000000;
        end

        // ------------------------------------------------------------
        // register writes
        // ------------------------------------------------------------
        if (write_done) begin
            unique case (idx)
                timer_counter_pkg::IDX_INTERRUPT_CONTROL: begin
                    state_d.global_irq_enable = wbyte[timer_counter_pkg::GLOBAL_IRQ_ENABLE_POS];
                    state_d.peripheral_irq_enable =
                        wbyte[timer_counter_pkg::PERIPHERAL_IRQ_ENABLE_POS];
                end
                timer_counter_pkg::IDX_IRQ_FLAGS_ONE: begin
                    state_d.overflow_irq_flag = wbyte[timer_counter_pkg::OVERFLOW_IRQ_POS];
                end
                timer_counter_pkg::IDX_COUNT_LOW_BYTE: begin
                    // write beats a trigger or an increment in the same cycle
                    state_d.count = {state_q.count[15:8], wbyte};
                    state_d.prescale_count = timer_counter_pkg::PRESCALE_RESET;
                end
                timer_counter_pkg::IDX_COUNT_HIGH_BYTE: begin
                    state_d.count = {wbyte, state_q.count[7:0]};
                    state_d.prescale_count = timer_counter_pkg::PRESCALE_RESET;
                end
                timer_counter_pkg::IDX_COUNTER_CONTROL: begin
                    state_d.ctrl = wbyte[5:0];
                end
                timer_counter_pkg::IDX_IRQ_ENABLES_ONE: begin
                    state_d.overflow_irq_enable = wbyte[timer_counter_pkg::OVERFLOW_IRQ_POS];
                end
                default: begin
                    state_d.ctrl = state_q.ctrl;
                end
            endcase
        end

        // a rollover in the clearing cycle still sets the flag
        if (overflow) begin
            state_d.overflow_irq_flag = 1'b1;
        end

        // ------------------------------------------------------------
        // interrupt request and wake
        // ------------------------------------------------------------
        state_d.irq_req = state_d.overflow_irq_flag & state_d.overflow_irq_enable &
                          state_d.peripheral_irq_enable & state_d.global_irq_enable;
        // wake needs only the local enable, as with other wake sources
        state_d.wake_req = state_d.overflow_irq_flag & state_d.overflow_irq_enable &
                           sleep_i;

        // ------------------------------------------------------------
        // resets, the count is kept by every one of them
        // ------------------------------------------------------------
        if (rst_i || device_reset_i) begin
            state_d.global_irq_enable = 1'b0;
            state_d.peripheral_irq_enable = 1'b0;
            state_d.overflow_irq_flag = 1'b0;
            state_d.overflow_irq_enable = 1'b0;
            state_d.prescale_count = timer_counter_pkg::PRESCALE_RESET;
            state_d.instr_div = 2'h0;
            state_d.source_prev = 1'b0;
            state_d.sync_tick = 1'b0;
            state_d.irq_req = 1'b0;
            state_d.wake_req = 1'b0;
            state_d.osc_drive = 1'b0;
            state_d.rsp = '0;
            state_d.count = state_q.count;
        end
        if (rst_i) begin
            state_d.ctrl = timer_counter_pkg::CONTROL_RESET;
            state_d.time_base_valid = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        state_q <= state_d;
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign apb_rsp_o = state_q.rsp;
    assign crystal_output_pin_o = state_q.osc_drive;
    assign time_base_o = state_q.count;
    assign time_base_valid_o = state_q.time_base_valid;
    assign overflow_irq_o = state_q.irq_req;
    assign wake_o = state_q.wake_req;

endmodule // timer_counter

// >>> timer_counter_pkg.sv
// constants and carrier types of the sixteen-bit event counter
package timer_counter_pkg;

    // ----------------------------------------------------------------
    // bus shape
    // ----------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int IDX_W = 10;

    // ----------------------------------------------------------------
    // register indices, byte address is four times the index
    // ----------------------------------------------------------------
    localparam logic [IDX_W-1:0] IDX_INTERRUPT_CONTROL = 10'h00B;
    localparam logic [IDX_W-1:0] IDX_IRQ_FLAGS_ONE = 10'h00C;
    localparam logic [IDX_W-1:0] IDX_COUNT_LOW_BYTE = 10'h00E;
    localparam logic [IDX_W-1:0] IDX_COUNT_HIGH_BYTE = 10'h00F;
    localparam logic [IDX_W-1:0] IDX_COUNTER_CONTROL = 10'h010;
    localparam logic [IDX_W-1:0] IDX_IRQ_ENABLES_ONE = 10'h08C;

    // ----------------------------------------------------------------
    // field positions and values
    // ----------------------------------------------------------------
    localparam int GLOBAL_IRQ_ENABLE_POS = 7;
    localparam int PERIPHERAL_IRQ_ENABLE_POS = 6;
    localparam int OVERFLOW_IRQ_POS = 0;
    localparam logic [5:0] CONTROL_RESET = 6'h00;
    localparam logic [3:0] COMPARE_MODE_TRIGGER = 4'hB;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
    localparam logic [2:0] PRESCALE_RESET = 3'h0;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [DATA_W-1:0] prdata;
    } apb_rsp_t;

    // bit order matches the control register, bit 5 down to bit 0
    typedef struct packed {
        logic [1:0] prescale_select_field;
        logic crystal_osc_enable_bit;
        logic sync_disable_bit;
        logic clock_source_select_bit;
        logic counter_on_bit;
    } counter_control_t;

    typedef struct packed {
        logic global_irq_enable;
        logic peripheral_irq_enable;
        logic overflow_irq_flag;
        logic overflow_irq_enable;
        counter_control_t ctrl;
        logic [15:0] count;
        logic [2:0] prescale_count;
        logic [1:0] instr_div;
        logic source_prev;
        logic sync_tick;
        logic irq_req;
        logic wake_req;
        logic osc_drive;
        logic time_base_valid;
        apb_rsp_t rsp;
    } state_t;

endpackage

// >>> count_source_model.sv
// external count pin and watch crystal source
`timescale 1ns/1ps
module count_source_model (
    input wire logic clock_i,
    output logic external_count_pin_o,
    output logic crystal_input_pin_o
);
    initial begin
        external_count_pin_o = 1'b0;
        crystal_input_pin_o = 1'b0;
    end
    // wide pulses so a synchronizer sees every edge; pins rest low between bursts
    task automatic send(input int n, input logic xtal);
        repeat (n) begin
            repeat (4) @(posedge clock_i);
            if (xtal) crystal_input_pin_o <= 1'b1;
            else external_count_pin_o <= 1'b1;
            repeat (4) @(posedge clock_i);
            crystal_input_pin_o <= 1'b0;
            external_count_pin_o <= 1'b0;
        end
        repeat (8) @(posedge clock_i);
    endtask
endmodule // count_source_model

// >>> timer_counter_monitor.sv
// concurrent checks on the event counter ports
`timescale 1ns/1ps
module timer_counter_monitor (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic device_reset_i,
    input wire logic sleep_i,
    input wire timer_counter_pkg::apb_req_t apb_req_i,
    input wire timer_counter_pkg::apb_rsp_t apb_rsp_o,
    input wire logic external_count_pin_i,
    input wire logic crystal_input_pin_i,
    input wire logic crystal_output_pin_o,
    input wire logic [3:0] compare_unit_mode_field_i,
    input wire logic [7:0] compare_value_high_i,
    input wire logic [7:0] compare_value_low_i,
    input wire logic [15:0] time_base_o,
    input wire logic time_base_valid_o,
    input wire logic overflow_irq_o,
    input wire logic wake_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    logic setup, done, wr_cnt;
    logic [5:0] ctrl_q, ctrl_d;
    assign setup = apb_req_i.psel && !apb_req_i.penable;
    assign done = apb_req_i.psel && apb_req_i.penable && apb_rsp_o.pready && apb_req_i.pwrite;
    assign wr_cnt = done && apb_req_i.paddr[11:3] == 9'h007 && apb_req_i.paddr[1:0] == 2'h0;
    // shadow of the control register, kept from completed writes
    always_comb begin
        ctrl_d = ctrl_q;
        if (done && apb_req_i.paddr == 12'h040) ctrl_d = apb_req_i.pwdata[5:0];
    end
    always_ff @(posedge clock_i) begin
        if (rst_i) ctrl_q <= 6'h00;
        else ctrl_q <= ctrl_d;
    end
    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence at_period_s;
        compare_unit_mode_field_i == timer_counter_pkg::COMPARE_MODE_TRIGGER
            && time_base_valid_o && time_base_o == {compare_value_high_i, compare_value_low_i};
    endsequence
    sequence moved_s;
        $changed(time_base_o) && !$past(wr_cnt) && !$past(wr_cnt, 2);
    endsequence
    ready_pulse_a: assert property (setup |=> apb_rsp_o.pready ##1 !apb_rsp_o.pready)
        else $error("pready is not one pulse after setup");
    upper_zero_a: assert property (apb_rsp_o.pready |-> apb_rsp_o.prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    reset_quiet_a: assert property (disable iff (1'b0) rst_i |=> !apb_rsp_o.pready
        && !overflow_irq_o && !wake_o && time_base_valid_o)
        else $error("outputs not quiet after reset");
    wake_sleep_a: assert property (wake_o |-> $past(sleep_i))
        else $error("wake without sleep");
    mode_valid_a: assert property (ctrl_q == $past(ctrl_q) && ctrl_q == $past(ctrl_q, 2)
        |-> time_base_valid_o == !(ctrl_q[1] && ctrl_q[2]))
        else $error("time base valid wrong for mode");
    crystal_drive_a: assert property (!$past(device_reset_i) && !$past(rst_i)
        |-> crystal_output_pin_o == ($past(ctrl_q[3]) && !$past(crystal_input_pin_i)))
        else $error("crystal amplifier output wrong");
    count_step_a: assert property (!$past(rst_i) ##0 moved_s
        |-> time_base_o == $past(time_base_o) + 16'h1 || time_base_o == 16'h0)
        else $error("count moved by other than one");
    trigger_wrap_a: assert property (at_period_s ##1 moved_s |-> time_base_o == 16'h0)
        else $error("count did not restart after compare match");
    // only the written byte is checked, the other one may still be unknown after power-up
    count_write_a: assert property (wr_cnt && !device_reset_i |=>
        (($past(apb_req_i.paddr[2]) ? time_base_o[15:8] : time_base_o[7:0])
        == $past(apb_req_i.pwdata[7:0])))
        else $error("written count byte not applied");
endmodule // timer_counter_monitor
bind timer_counter timer_counter_monitor mon (.clock_i, .rst_i, .device_reset_i, .sleep_i,
    .apb_req_i, .apb_rsp_o, .external_count_pin_i, .crystal_input_pin_i, .crystal_output_pin_o,
    .compare_unit_mode_field_i, .compare_value_high_i, .compare_value_low_i, .time_base_o,
    .time_base_valid_o, .overflow_irq_o, .wake_o);

// >>> testbench.sv
// self-checking bench for the event counter
`timescale 1ns/1ps
module testbench;
    logic clock_i, rst_i, device_reset_i, sleep_i, xout, tbv, irq, wake, ext_pin, xtal_pin, err;
    timer_counter_pkg::apb_req_t req;
    timer_counter_pkg::apb_rsp_t rsp;
    logic [3:0] cmp_mode;
    logic [15:0] cmp, tb;
    logic [31:0] rd;
    int error_cnt = 0;
    int tests_run = 0;
    int hi = 0;
    timer_counter dut (.clock_i, .rst_i, .device_reset_i, .sleep_i, .apb_req_i(req),
        .apb_rsp_o(rsp), .external_count_pin_i(ext_pin), .crystal_input_pin_i(xtal_pin),
        .crystal_output_pin_o(xout), .compare_unit_mode_field_i(cmp_mode),
        .compare_value_high_i(cmp[15:8]), .compare_value_low_i(cmp[7:0]), .time_base_o(tb),
        .time_base_valid_o(tbv), .overflow_irq_o(irq), .wake_o(wake));
    count_source_model src (.clock_i, .external_count_pin_o(ext_pin),
        .crystal_input_pin_o(xtal_pin));
    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic stop_test();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one idle edge before each setup keeps the request from being driven twice per step
    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock_i);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clock_i);
        req.penable <= 1'b1;
        do begin
            @(posedge clock_i);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        if (n >= 20) error_cnt++;
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0);
        chk(rd, exp);
    endtask
    task automatic set_count(input logic [7:0] h, input logic [7:0] l, input logic [7:0] c);
        wr(12'h040, 32'h0);
        wr(12'h038, {24'h0, l});
        wr(12'h03C, {24'h0, h});
        wr(12'h040, {24'h0, c});
    endtask
    // ----------------------------------------------------------------
    // sequence
    // ----------------------------------------------------------------
    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end
    initial begin
        #100000;
        error_cnt++;
        stop_test();
    end
    initial begin
        rst_i = 1'b1;
        device_reset_i = 1'b0;
        sleep_i = 1'b0;
        req = '0;
        cmp_mode = 4'h0;
        cmp = 16'h0;
        repeat (5) @(posedge clock_i);
        rst_i <= 1'b0;
        rdchk(12'h040, 32'h0);
        rdchk(12'h230, 32'h0);
        wr(12'h040, 32'hFC);
        rdchk(12'h040, 32'h3C);
        wr(12'h02C, 32'hFF);
        rdchk(12'h02C, 32'hC0);
        xfer(12'h044, 1'b0, 32'h0);
        chk(32'(err), 32'h1);
        wr(12'h230, 32'h1);
        set_count(8'hFF, 8'hFE, 8'h01);
        repeat (40) @(posedge clock_i);
        wr(12'h040, 32'h0);
        rdchk(12'h030, 32'h1);
        rdchk(12'h03C, 32'h0);
        chk(32'(irq), 32'h1);
        wr(12'h030, 32'h0);
        repeat (2) @(posedge clock_i);
        chk(32'(irq), 32'h0);
        // prescale 1:1 to 1:8 over 128 clocks, phase allows one count either way
        for (int p = 0; p < 4; p++) begin
            set_count(8'h0, 8'h0, 8'(p * 16 + 1));
            repeat (126) @(posedge clock_i);
            wr(12'h040, 32'h0);
            xfer(12'h038, 1'b0, 32'h0);
            chk(32'(rd + 1 >= (32 >> p) && rd <= (32 >> p) + 1), 32'h1);
        end
        set_count(8'h0, 8'h0, 8'h03);
        src.send(5, 1'b0);
        rdchk(12'h038, 32'h5);
        wr(12'h040, 32'h0B);
        repeat (20) @(posedge clock_i);
        src.send(3, 1'b0);
        src.send(3, 1'b1);
        rdchk(12'h038, 32'h8);
        wr(12'h040, 32'h03);
        sleep_i <= 1'b1;
        src.send(4, 1'b0);
        sleep_i <= 1'b0;
        rdchk(12'h038, 32'h8);
        set_count(8'hFF, 8'hFE, 8'h07);
        sleep_i <= 1'b1;
        src.send(3, 1'b0);
        chk(32'(wake), 32'h1);
        chk(32'(tbv), 32'h0);
        sleep_i <= 1'b0;
        rdchk(12'h038, 32'h1);
        wr(12'h030, 32'h0);
        cmp <= 16'h0005;
        cmp_mode <= 4'hB;
        set_count(8'h0, 8'h0, 8'h01);
        repeat (100) begin
            @(posedge clock_i);
            if (tb > 16'h5) hi++;
        end
        chk(hi, 0);
        // running count read as high, low, high; equal highs mean a clean pair
        rdchk(12'h03C, 32'h0);
        xfer(12'h038, 1'b0, 32'h0);
        chk(32'(rd <= 32'h5), 32'h1);
        rdchk(12'h03C, 32'h0);
        set_count(8'h0, 8'h0, 8'h07);
        src.send(7, 1'b0);
        rdchk(12'h038, 32'h7);
        rdchk(12'h030, 32'h0);
        set_count(8'h12, 8'h34, 8'h30);
        device_reset_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        device_reset_i <= 1'b0;
        rdchk(12'h040, 32'h30);
        rdchk(12'h03C, 32'h12);
        rst_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        rst_i <= 1'b0;
        rdchk(12'h040, 32'h0);
        rdchk(12'h038, 32'h34);
        stop_test();
    end
endmodule // testbench
